/* File: hw/asrx_pkg.sv */
package asrx_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_BAUD_HIGH = 5'h00;
    localparam logic [4:0] OFS_BAUD_LOW  = 5'h04;
    localparam logic [4:0] OFS_CTRL_ONE  = 5'h08;
    localparam logic [4:0] OFS_CTRL_TWO  = 5'h0c;
    localparam logic [4:0] OFS_STATUS    = 5'h10;
    localparam logic [4:0] OFS_CTRL_THR  = 5'h14;
    localparam logic [4:0] OFS_DATA      = 5'h18;
    // reset values
    localparam logic [4:0] RST_BAUD_HIGH = 5'h00;
    localparam logic [7:0] RST_BAUD_LOW  = 8'h04;
    // control one fields
    localparam int C1_LOOP   = 7;
    localparam int C1_SRC    = 5;
    localparam int C1_NINE   = 4;
    localparam int C1_WAKE   = 3;
    localparam int C1_QUIET  = 2;
    localparam int C1_PAR_EN = 1;
    localparam int C1_ODD    = 0;
    // control two fields
    localparam int C2_TXE_IE  = 7;
    localparam int C2_TXD_IE  = 6;
    localparam int C2_RXF_IE  = 5;
    localparam int C2_IDLE_IE = 4;
    localparam int C2_TX_ON   = 3;
    localparam int C2_RX_ON   = 2;
    localparam int C2_STANDBY = 1;
    // control three fields; bits 3..0 mask overrun, noise, framing, parity
    localparam int C3_RX9 = 7;
    localparam int C3_TX9 = 6;
    localparam int C3_DIR = 5;
    // status fields
    localparam int S_TX_BUFFER_EMPTY = 7;
    localparam int S_TC   = 6;
    localparam int S_RX_BUFFER_FULL = 5;
    localparam int S_IDLE = 4;
    localparam int S_OVR  = 3;
    localparam int S_NF   = 2;
    localparam int S_FE   = 1;
    localparam int S_PF   = 0;
    // timing
    localparam logic [3:0] LAST_PHASE  = 4'hf;
    localparam logic [3:0] SAMPLE_A    = 4'h7;
    localparam logic [3:0] SAMPLE_C    = 4'h9;
    localparam logic [3:0] BITS_EIGHT  = 4'ha;
    localparam logic [3:0] BITS_NINE   = 4'hb;
    // stop mode codes
    localparam logic [1:0] STOP_NONE  = 2'h0;
    localparam logic [1:0] STOP_LIGHT = 2'h3;
endpackage : asrx_pkg

/* File: hw/asrx_baud_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface asrx_baud_if;
    logic [12:0] divisor;
    logic        enable;
    logic        tick;
    modport gen  (input divisor, input enable, output tick);
    modport user (output divisor, output enable, input tick);
endinterface : asrx_baud_if
`default_nettype wire

/* File: hw/asrx_baud_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module asrx_baud_gen (
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   reset_in,
    input  wire logic   halt_in,
    // divisor and tick
    asrx_baud_if.gen    baud
);
    import asrx_pkg::*;
    logic [12:0] count;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count     <= 13'h0000;
            baud.tick <= 1'b0;
        end else if (!halt_in) begin
            if (!baud.enable || baud.divisor == 13'h0000) begin
                count     <= 13'h0000;
                baud.tick <= 1'b0;
            end else if (count >= baud.divisor - 13'h0001) begin
                // one tick per divisor clocks gives sixteen ticks per bit
                count     <= 13'h0000;
                baud.tick <= 1'b1;
            end else begin
                count     <= count + 13'h0001;
                baud.tick <= 1'b0;
            end
        end
    end
endmodule : asrx_baud_gen
`default_nettype wire

/* File: hw/asrx_top.sv */
`timescale 1ns/1ns
`default_nettype none
module asrx_top (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [1:0]  stop_mode_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [4:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // serial pins
    input  wire logic        rx_pin_in,
    input  wire logic        tx_pin_in,
    output logic             tx_pin_out,
    output logic             tx_pin_oe_out,
    output logic             rx_pin_used_out,
    // interrupt requests
    output logic             tx_irq_out,
    output logic             rx_irq_out,
    output logic             err_irq_out
);
    import asrx_pkg::*;

    asrx_baud_if baud ();

    logic [1:0] stop_meta, stop_sync, stop_hold, stop_code;
    logic [1:0] rx_meta, rx_sync, txp_meta, txp_sync;
    logic       halt, deep, rst;
    logic [4:0] baud_high_buf, baud_high;
    logic [7:0] baud_low, ctrl1, ctrl2, ctrl3m;
    logic       tx9, dir, rx9, baud_started;
    logic [7:0] status, armed, tx_buf, rx_buf;
    logic       access, rd_status, rd_data, wr_data;
    logic       nine;
    logic       tx_busy, pre_pending, tx_on_d;
    logic [10:0] tx_sh;
    logic [3:0] tx_ph, tx_left;
    logic       tx_line, rx_line;
    logic       rx_busy;
    logic [3:0] rx_ph, rx_bit, idle_ph, idle_bits;
    logic [8:0] rx_sh;
    logic [2:0] smp;
    logic       rx_noise, rx_done, rx_frame_err, idle_armed, idle_hit;
    logic       maj, bit_noise, par_bit, par_err;
    logic [7:0] rx_data_new;
    logic       set_rx_buffer_full, set_ovr, set_idle, mark_wake;

    // stop code and serial inputs come from outside the clock domain
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stop_meta <= STOP_NONE;
            stop_sync <= STOP_NONE;
            stop_hold <= STOP_NONE;
            stop_code <= STOP_NONE;
            rx_meta   <= 2'h3;
            rx_sync   <= 2'h3;
            txp_meta  <= 2'h3;
            txp_sync  <= 2'h3;
        end else begin
            stop_meta <= stop_mode_in;
            stop_sync <= stop_meta;
            stop_hold <= stop_sync;
            // code taken only when read twice alike, so a 0 to 3 move
            // cannot pass through a false deep stop code
            if (stop_sync == stop_hold) begin
                stop_code <= stop_sync;
            end
            rx_meta   <= {rx_meta[0], rx_pin_in};
            rx_sync   <= {rx_sync[0], rx_meta[1]};
            txp_meta  <= {txp_meta[0], tx_pin_in};
            txp_sync  <= {txp_sync[0], txp_meta[1]};
        end
    end

    // lightest stop freezes, deeper stops wipe state
    assign halt = (stop_code == STOP_LIGHT);
    assign deep = (stop_code != STOP_NONE) && !halt;
    assign rst  = reset_in || deep;
    assign nine = ctrl1[C1_NINE];

    // apb: one wait state so read data can come from a flop
    assign access    = psel_in && penable_in && pready_out;
    assign rd_status = access && !pwrite_in && paddr_in == OFS_STATUS;
    assign rd_data   = access && !pwrite_in && paddr_in == OFS_DATA;
    assign wr_data   = access && pwrite_in && paddr_in == OFS_DATA;

    always_ff @(posedge clk_in) begin
        if (rst) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else if (!halt) begin
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= 1'b0;
            if (psel_in && penable_in && !pready_out) begin
                unique case (paddr_in)
                    OFS_BAUD_HIGH: prdata_out <= {27'h0, baud_high};
                    OFS_BAUD_LOW:  prdata_out <= {24'h0, baud_low};
                    OFS_CTRL_ONE:  prdata_out <= {24'h0, ctrl1};
                    OFS_CTRL_TWO:  prdata_out <= {24'h0, ctrl2};
                    OFS_STATUS:    prdata_out <= {24'h0, status};
                    OFS_CTRL_THR:  prdata_out <= {24'h0, rx9, tx9, dir, 1'b0, ctrl3m[3:0]};
                    OFS_DATA:      prdata_out <= {24'h0, rx_buf};
                    default: begin
                        prdata_out  <= 32'h0000_0000;
                        pslverr_out <= 1'b1;
                    end
                endcase
            end
        end
    end

    // control registers
    always_ff @(posedge clk_in) begin
        if (rst) begin
            baud_high_buf <= RST_BAUD_HIGH;
            baud_high     <= RST_BAUD_HIGH;
            baud_low      <= RST_BAUD_LOW;
            ctrl1         <= 8'h00;
            ctrl3m        <= 8'h00;
            tx9           <= 1'b0;
            dir           <= 1'b0;
            baud_started  <= 1'b0;
        end else if (!halt) begin
            if (access && pwrite_in) begin
                unique case (paddr_in)
                    // high half held until low half written
                    OFS_BAUD_HIGH: baud_high_buf <= pwdata_in[4:0];
                    OFS_BAUD_LOW: begin
                        baud_low  <= pwdata_in[7:0];
                        baud_high <= baud_high_buf;
                    end
                    OFS_CTRL_ONE: ctrl1 <= pwdata_in[7:0];
                    OFS_CTRL_THR: begin
                        ctrl3m <= {4'h0, pwdata_in[3:0]};
                        tx9    <= pwdata_in[C3_TX9];
                        dir    <= pwdata_in[C3_DIR];
                    end
                    OFS_CTRL_TWO: if (pwdata_in[C2_TX_ON] || pwdata_in[C2_RX_ON]) begin
                        baud_started <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // control two: standby is set by software and cleared by wakeup
    always_ff @(posedge clk_in) begin
        if (rst) begin
            ctrl2 <= 8'h00;
        end else if (!halt) begin
            if (access && pwrite_in && paddr_in == OFS_CTRL_TWO) begin
                ctrl2 <= {pwdata_in[7:2], pwdata_in[C2_STANDBY], 1'b0};
            end else if (ctrl2[C2_STANDBY]) begin
                if (!ctrl1[C1_WAKE] && idle_hit) begin
                    ctrl2[C2_STANDBY] <= 1'b0;
                end
                if (ctrl1[C1_WAKE] && rx_done && rx_sh[8]) begin
                    ctrl2[C2_STANDBY] <= 1'b0;
                end
            end
        end
    end

    // generator runs only for a non-zero divisor
    assign baud.divisor = {baud_high, baud_low};
    // enable held off until first receiver or transmitter enable
    assign baud.enable  = baud_started;

    asrx_baud_gen u_baud (
        .clk_in   (clk_in),
        .reset_in (rst),
        .halt_in  (halt),
        .baud     (baud.gen)
    );

    // receiver source and tx pin direction
    always_comb begin
        if (!ctrl1[C1_LOOP]) begin
            rx_line = rx_sync[1];
        end else if (!ctrl1[C1_SRC]) begin
            rx_line = tx_line;
        end else if (dir) begin
            rx_line = tx_line;
        end else begin
            rx_line = txp_sync[1];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst) begin
            tx_pin_out      <= 1'b1;
            tx_pin_oe_out   <= 1'b0;
            rx_pin_used_out <= 1'b0;
        end else if (!halt) begin
            tx_pin_out      <= tx_line;
            // transmitter keeps the pin until its frame finishes
            tx_pin_oe_out   <= (ctrl2[C2_TX_ON] || tx_busy)
                               && (!ctrl1[C1_LOOP] || (ctrl1[C1_SRC] && dir));
            rx_pin_used_out <= ctrl2[C2_RX_ON] && !ctrl1[C1_LOOP];
        end
    end

    // transmitter: framing, ninth bit copied at transfer
    assign tx_line = tx_busy ? tx_sh[0] : 1'b1;
    assign par_bit = nine ? (^tx_buf ^ ctrl1[C1_ODD]) : (^tx_buf[6:0] ^ ctrl1[C1_ODD]);

    always_ff @(posedge clk_in) begin
        if (rst) begin
            tx_busy     <= 1'b0;
            pre_pending <= 1'b0;
            tx_on_d     <= 1'b0;
            tx_sh       <= 11'h7ff;
            tx_ph       <= 4'h0;
            tx_left     <= 4'h0;
        end else if (!halt) begin
            tx_on_d <= ctrl2[C2_TX_ON];
            if (ctrl2[C2_TX_ON] && !tx_on_d) begin
                pre_pending <= 1'b1;
            end
            if (tx_busy) begin
                if (baud.tick) begin
                    tx_ph <= tx_ph + 4'h1;
                    if (tx_ph == LAST_PHASE) begin
                        tx_sh   <= {1'b1, tx_sh[10:1]};
                        tx_left <= tx_left - 4'h1;
                        tx_busy <= (tx_left != 4'h1);
                    end
                end
            end else if (ctrl2[C2_TX_ON] && pre_pending) begin
                // preamble: one full frame of high level
                pre_pending <= 1'b0;
                tx_busy     <= 1'b1;
                tx_sh       <= 11'h7ff;
                tx_ph       <= 4'h0;
                tx_left     <= nine ? BITS_NINE : BITS_EIGHT;
            end else if (ctrl2[C2_TX_ON] && !status[S_TX_BUFFER_EMPTY]) begin
                tx_busy <= 1'b1;
                tx_ph   <= 4'h0;
                tx_left <= nine ? BITS_NINE : BITS_EIGHT;
                if (nine) begin
                    tx_sh <= {1'b1, ctrl1[C1_PAR_EN] ? par_bit : tx9, tx_buf, 1'b0};
                end else begin
                    tx_sh <= {2'h3, ctrl1[C1_PAR_EN] ? par_bit : tx_buf[7],
                              tx_buf[6:0], 1'b0};
                end
            end
        end
    end

    // receiver sampling at sixteen ticks per bit, majority of three
    assign maj       = (smp[0] & smp[1]) | (smp[0] & rx_line) | (smp[1] & rx_line);
    assign bit_noise = !(smp[0] == smp[1] && smp[1] == rx_line);
    assign rx_data_new = nine ? rx_sh[7:0] : rx_sh[8:1];
    assign par_err   = ctrl1[C1_PAR_EN]
                       && ((nine ? ^rx_sh : ^rx_sh[8:1]) != ctrl1[C1_ODD]);

    always_ff @(posedge clk_in) begin
        if (rst) begin
            rx_busy      <= 1'b0;
            rx_ph        <= 4'h0;
            rx_bit       <= 4'h0;
            rx_sh        <= 9'h000;
            smp          <= 3'h7;
            rx_noise     <= 1'b0;
            rx_done      <= 1'b0;
            rx_frame_err <= 1'b0;
        end else if (!halt) begin
            rx_done <= 1'b0;
            if (!ctrl2[C2_RX_ON]) begin
                rx_busy <= 1'b0;
            end else if (baud.tick) begin
                if (!rx_busy) begin
                    if (!rx_line) begin
                        rx_busy  <= 1'b1;
                        rx_ph    <= 4'h1;
                        rx_bit   <= 4'h0;
                        rx_noise <= 1'b0;
                    end
                end else begin
                    rx_ph <= rx_ph + 4'h1;
                    if (rx_ph >= SAMPLE_A && rx_ph < SAMPLE_C) begin
                        smp <= {smp[1:0], rx_line};
                    end
                    if (rx_ph == SAMPLE_C) begin
                        rx_noise <= rx_noise || bit_noise;
                        if (rx_bit == 4'h0 && maj) begin
                            rx_busy <= 1'b0;
                        end else if (rx_bit == (nine ? BITS_NINE : BITS_EIGHT) - 4'h1) begin
                            // stop bit decided: hand over the character
                            rx_busy      <= 1'b0;
                            rx_done      <= 1'b1;
                            rx_frame_err <= !maj;
                        end else if (rx_bit != 4'h0) begin
                            rx_sh <= nine ? {maj, rx_sh[8:1]} : {maj, rx_sh[8:1]};
                        end
                    end
                    if (rx_ph == LAST_PHASE) begin
                        rx_bit <= rx_bit + 4'h1;
                    end
                end
            end
        end
    end

    // idle detection counts bit times of high line
    always_ff @(posedge clk_in) begin
        if (rst) begin
            idle_ph   <= 4'h0;
            idle_bits <= 4'h0;
            idle_hit  <= 1'b0;
        end else if (!halt) begin
            idle_hit <= 1'b0;
            // type 1 keeps the count at zero until the stop bit is sampled
            if (!rx_line || (ctrl1[C1_QUIET] && rx_busy) || !ctrl2[C2_RX_ON]) begin
                idle_ph   <= 4'h0;
                idle_bits <= 4'h0;
            end else if (baud.tick && idle_bits != 4'hf) begin
                idle_ph <= idle_ph + 4'h1;
                if (idle_ph == LAST_PHASE) begin
                    idle_bits <= idle_bits + 4'h1;
                    if (idle_bits + 4'h1 == (nine ? BITS_NINE : BITS_EIGHT)) begin
                        idle_hit <= 1'b1;
                    end
                end
            end
        end
    end

    // the address character that wakes the receiver is itself received
    assign mark_wake = ctrl1[C1_WAKE] && rx_done && rx_sh[8];
    // standby blocks receiver flags; full buffer means overrun
    assign set_rx_buffer_full = rx_done && (!ctrl2[C2_STANDBY] || mark_wake) && !status[S_RX_BUFFER_FULL];
    assign set_ovr  = rx_done && (!ctrl2[C2_STANDBY] || mark_wake) && status[S_RX_BUFFER_FULL];
    // idle sets once per received character
    assign set_idle = idle_hit && idle_armed && !ctrl2[C2_STANDBY];

    always_ff @(posedge clk_in) begin
        if (rst) begin
            armed <= 8'h00;
        end else if (!halt) begin
            if (rd_status) begin
                armed <= status;
            end else if (rd_data || wr_data) begin
                armed <= 8'h00;
            end
        end
    end

    // status flags: a set in the clearing cycle wins
    always_ff @(posedge clk_in) begin
        if (rst) begin
            status     <= 8'hc0;
            rx_buf     <= 8'h00;
            rx9        <= 1'b0;
            tx_buf     <= 8'h00;
            idle_armed <= 1'b0;
        end else if (!halt) begin
            if (wr_data) begin
                tx_buf <= pwdata_in[7:0];
            end
            // data read after status read clears receiver flags
            if (rd_data) begin
                status[5:0] <= status[5:0] & ~armed[5:0];
            end
            if (wr_data && armed[S_TX_BUFFER_EMPTY]) begin
                status[S_TX_BUFFER_EMPTY] <= 1'b0;
            end
            if (!tx_busy && ctrl2[C2_TX_ON] && !pre_pending && !status[S_TX_BUFFER_EMPTY]) begin
                status[S_TX_BUFFER_EMPTY] <= 1'b1;
            end
            // done flag follows an idle-high transmitter
            status[S_TC] <= status[S_TX_BUFFER_EMPTY] && !tx_busy && !pre_pending;
            if (set_rx_buffer_full) begin
                status[S_RX_BUFFER_FULL] <= 1'b1;
                rx_buf         <= rx_data_new;
                rx9            <= rx_sh[8];
                idle_armed     <= 1'b1;
                // errors ride with the full flag
                status[S_NF]   <= rx_noise;
                status[S_FE]   <= rx_frame_err;
                status[S_PF]   <= par_err;
            end
            // new character and its errors dropped
            if (set_ovr) begin
                status[S_OVR] <= 1'b1;
            end
            if (set_idle) begin
                status[S_IDLE] <= 1'b1;
                idle_armed     <= 1'b0;
            end
        end
    end

    // three requests from eight masked sources
    always_ff @(posedge clk_in) begin
        if (rst) begin
            tx_irq_out  <= 1'b0;
            rx_irq_out  <= 1'b0;
            err_irq_out <= 1'b0;
        end else if (!halt) begin
            tx_irq_out  <= (status[S_TX_BUFFER_EMPTY] && ctrl2[C2_TXE_IE])
                           || (status[S_TC] && ctrl2[C2_TXD_IE]);
            rx_irq_out  <= (status[S_RX_BUFFER_FULL] && ctrl2[C2_RXF_IE])
                           || (status[S_IDLE] && ctrl2[C2_IDLE_IE]);
            err_irq_out <= |(status[3:0] & ctrl3m[3:0]);
        end
    end
endmodule : asrx_top
`default_nettype wire

/* File: bench/asrx_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module asrx_props (
    // bus side
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic [1:0]  stop_mode_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // pins and requests
    input wire logic        tx_pin_out,
    input wire logic        tx_pin_oe_out,
    input wire logic        rx_pin_used_out,
    input wire logic        tx_irq_out,
    input wire logic        rx_irq_out,
    input wire logic        err_irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_req; psel_in && $rose(penable_in); endsequence
    sequence s_ans; !pready_out ##1 pready_out; endsequence
    AST_ANSWER: assert property (s_req |-> s_ans)
        else $error("bus answer not on second access cycle");
    AST_PULSE: assert property (pready_out |=> !pready_out)
        else $error("ready held past one cycle");
    AST_ERR: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error response without ready or with data");
    AST_LANE: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    AST_RST_PIN: assert property ($fell(reset_in) |-> tx_pin_out && !tx_pin_oe_out && !rx_pin_used_out)
        else $error("pins not idle after reset");
    AST_RST_IRQ: assert property ($fell(reset_in) |-> !tx_irq_out && !rx_irq_out && !err_irq_out)
        else $error("request raised out of reset");
    AST_DEEP: assert property ((stop_mode_in == 2'h1) [*7] |-> !tx_pin_oe_out && !rx_irq_out)
        else $error("deep stop did not clear state");
    AST_LIGHT: assert property ((stop_mode_in == 2'h3) [*5] |=> $stable(tx_pin_out) && $stable(tx_irq_out))
        else $error("light stop did not freeze");
endmodule : asrx_props
bind asrx_top asrx_props u_props (.clk_in, .reset_in, .stop_mode_in, .psel_in, .penable_in,
    .prdata_out, .pready_out, .pslverr_out, .tx_pin_out, .tx_pin_oe_out, .rx_pin_used_out,
    .tx_irq_out, .rx_irq_out, .err_irq_out);
`default_nettype wire

/* File: bench/asrx_remote.sv */
`timescale 1ns/1ns
`default_nettype none
module asrx_remote #(parameter int BT = 16) (
    // line
    input  wire logic clk_in,
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] b;
    logic [7:0] got[$];
    initial line_out = 1'b1;
    task send(input logic [8:0] v, input int nb);
        line_out <= 1'b0;
        repeat (BT) @(posedge clk_in);
        for (int i = 0; i < nb; i++) begin
            line_out <= v[i];
            repeat (BT) @(posedge clk_in);
        end
        line_out <= 1'b1;
        repeat (BT) @(posedge clk_in);
    endtask : send
    always begin
        @(negedge line_in);
        repeat (BT + BT / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            b[i] = line_in;
            repeat (BT) @(posedge clk_in);
        end
        got.push_back(b);
    end
endmodule : asrx_remote
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import asrx_pkg::*;
    logic        clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [1:0]  stop_mode_in = 2'h0;
    logic [4:0]  paddr_in = 5'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic        pready_out, pslverr_out, er, rx_line, tx_pin_out, tx_pin_oe_out;
    logic        rx_pin_used_out, tx_irq_out, rx_irq_out, err_irq_out;
    logic [7:0]  v, q[$];
    int          n_errors = 0, num_checks = 0, seed = 32'h37d9cf97, i;
    // released tx pin sits at its pull-up level
    wire         tx_line = tx_pin_oe_out ? tx_pin_out : 1'b1;
    asrx_top uut (.clk_in, .reset_in, .stop_mode_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_pin_in(rx_line),
        .tx_pin_in(tx_line), .tx_pin_out, .tx_pin_oe_out, .rx_pin_used_out, .tx_irq_out,
        .rx_irq_out, .err_irq_out);
    asrx_remote #(.BT(16)) far (.clk_in, .line_in(tx_line), .line_out(rx_line));
    initial forever #2 clk_in = ~clk_in;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // ready is looked at on rising edges only; the limit ends a hang
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (pready_out !== 1'b1 && i < 20);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (pready_out !== 1'b1) n_errors++;
    endtask : apb
    task rx_wait;
        for (int j = 0; j < 100; j++) begin
            apb(0, OFS_STATUS, 0);
            if (rd[S_RX_BUFFER_FULL] === 1'b1) break;
        end
    endtask : rx_wait
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        #60000;
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        apb(0, OFS_STATUS, 0);
        chk(rd, 32'hc0);
        apb(0, OFS_BAUD_LOW, 0);
        chk(rd, {24'h0, RST_BAUD_LOW});
        apb(0, 5'h1c, 0);
        chk({31'h0, er}, 32'h1);
        apb(1, OFS_BAUD_HIGH, 0);
        apb(1, OFS_BAUD_LOW, 1);
        apb(1, OFS_CTRL_THR, 32'h08);
        apb(1, OFS_CTRL_TWO, 32'h2c);
        $display("test setup done");
        for (int k = 0; k < 3; k++) begin
            v = $random(seed);
            q.push_back(v);
            far.send({1'b0, v}, 8);
            if (k == 2) far.send({1'b0, ~v}, 8);
            rx_wait;
            chk({31'h0, rx_irq_out}, 32'h1);
            chk({31'h0, err_irq_out}, {31'h0, k == 2});
            chk(rd & 32'h2f, (k == 2) ? 32'h28 : 32'h20);
            apb(0, OFS_DATA, 0);
            chk(rd, {24'h0, q.pop_front()});
            apb(0, OFS_STATUS, 0);
            chk(rd & 32'h28, 0);
        end
        $display("test receive done");
        apb(1, OFS_CTRL_ONE, 32'h08);
        apb(1, OFS_CTRL_TWO, 32'h2e);
        far.send({1'b0, v & 8'h7f}, 8);
        apb(0, OFS_STATUS, 0);
        chk(rd & 32'h2f, 0);
        far.send({1'b0, v | 8'h80}, 8);
        rx_wait;
        apb(0, OFS_DATA, 0);
        chk(rd, {24'h0, v | 8'h80});
        apb(0, OFS_CTRL_TWO, 0);
        chk(rd & 32'h2, 0);
        // idle count saturates first, so only idle after the next frame wakes
        apb(1, OFS_CTRL_ONE, 32'h04);
        repeat (200) @(posedge clk_in);
        apb(1, OFS_CTRL_TWO, 32'h2e);
        far.send({1'b0, v | 8'hf0}, 8);
        for (int k = 0; k < 3; k++) begin
            apb(0, OFS_CTRL_TWO, 0);
            chk(rd & 32'h2, (k < 2) ? 32'h2 : 32'h0);
            repeat (100) @(posedge clk_in);
        end
        apb(1, OFS_CTRL_ONE, 32'h10);
        far.send({1'b1, v}, 9);
        rx_wait;
        // ninth bit read before data register
        apb(0, OFS_CTRL_THR, 0);
        chk(rd & 32'h80, 32'h80);
        apb(0, OFS_DATA, 0);
        chk(rd, {24'h0, v});
        $display("test standby done");
        apb(1, OFS_CTRL_ONE, 0);
        apb(1, OFS_CTRL_TWO, 32'h8c);
        repeat (3) @(posedge clk_in);
        chk({31'h0, tx_irq_out}, 32'h1);
        apb(0, OFS_STATUS, 0);
        v = $random(seed);
        apb(1, OFS_DATA, {24'h0, v});
        for (int k = 0; k < 2000 && far.got.size() == 0; k++) @(posedge clk_in);
        chk(far.got.size(), 1);
        chk({24'h0, far.got.pop_front()}, {24'h0, v});
        chk({31'h0, rx_pin_used_out}, 32'h1);
        apb(1, OFS_CTRL_ONE, 32'h80);
        repeat (3) @(posedge clk_in);
        chk({30'h0, rx_pin_used_out, tx_pin_oe_out}, 0);
        $display("test transmit done");
        stop_mode_in <= STOP_LIGHT;
        repeat (8) @(posedge clk_in);
        stop_mode_in <= 2'h1;
        repeat (8) @(posedge clk_in);
        stop_mode_in <= STOP_NONE;
        repeat (8) @(posedge clk_in);
        apb(0, OFS_CTRL_TWO, 0);
        chk(rd, 0);
        $display("test stop done");
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
